// ---- hdl/sdc_params.svh ----
`ifndef SDC_PARAMS_SVH
`define SDC_PARAMS_SVH

// Register byte addresses.
`define SDC_ADDR_MASTER_EN      8'h05
`define SDC_ADDR_CH0_VOLT       8'h80
`define SDC_ADDR_CH0_CTRL       8'h81
`define SDC_ADDR_CH1_VOLT       8'h82
`define SDC_ADDR_CH1_CTRL       8'h83
`define SDC_ADDR_CH2_VOLT       8'h84
`define SDC_ADDR_CH2_CTRL       8'h85

// Field positions.
`define SDC_VOLT_EN_BIT         7
`define SDC_CTRL_PFM_BIT        0
`define SDC_CTRL_RATE_BIT       1
`define SDC_CTRL_ILIM_LO        2
`define SDC_CTRL_ILIM_HI        3
`define SDC_CTRL_SHORT_BIT      4
`define SDC_CTRL_GOOD_BIT       5
`define SDC_CTRL_UNLOCK_BIT     7
`define SDC_CTRL_RW_MASK        8'hCF

// Reset values.
`define SDC_CH0_CODE_RST        7'h66
`define SDC_CH1_CODE_RST        7'h2A
`define SDC_CH2_CODE_RST        7'h12
`define SDC_CTRL_RST            8'hCE
`define SDC_MASTER_RST          3'h0

// Timing: times in ns, counts derived from the clock period.
`define SDC_CLK_PERIOD_NS       50
`define SDC_SS_DELAY_NS         50000
`define SDC_STEP_NS             2000
`define SDC_SS_DELAY_CYC        ((`SDC_SS_DELAY_NS + `SDC_CLK_PERIOD_NS - 1) / `SDC_CLK_PERIOD_NS)
`define SDC_STEP_CYC            (`SDC_STEP_NS / `SDC_CLK_PERIOD_NS)

`endif

// ---- hdl/sdc_pkg.sv ----
package sdc_pkg;
    typedef enum logic [2:0] {
        SDC_OFF,
        SDC_DELAY,
        SDC_RAMP,
        SDC_RUN,
        SDC_FAULT
    } sdc_ss_state_e;
endpackage

// ---- hdl/sdc_channel.sv ----
`timescale 1ns/1ps
`include "sdc_params.svh"

module sdc_channel (
    input  wire logic       i_clk_sys,
    input  wire logic       i_arst_n,
    input  wire logic       i_master_en,
    input  wire logic       i_local_en,
    input  wire logic [6:0] i_code,
    input  wire logic       i_step_tick,
    input  wire logic       i_short_raw,
    input  wire logic       i_good_raw,
    output logic            o_on,
    output logic [6:0]      o_ref_code,
    output logic            o_ramping,
    output logic            o_short_flag,
    output logic            o_good
);
    sdc_pkg::sdc_ss_state_e state_reg, state_next;
    logic [10:0] dly_reg;
    logic [6:0]  ref_reg;
    logic        local_prev_reg;
    logic        flag_reg;
    logic        sc_s1_reg, sc_s2_reg, gd_s1_reg, gd_s2_reg;

    wire logic en        = i_master_en & i_local_en;
    wire logic local_up  = i_local_en & ~local_prev_reg;
    wire logic dly_done  = (dly_reg == 11'(`SDC_SS_DELAY_CYC - 1));
    wire logic active    = (state_reg == sdc_pkg::SDC_DELAY) || (state_reg == sdc_pkg::SDC_RAMP)
                           || (state_reg == sdc_pkg::SDC_RUN);
    wire logic short_hit = active & sc_s2_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Status inputs pass two flip-flops before any use.
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sc_s1_reg <= 1'b0;
            sc_s2_reg <= 1'b0;
            gd_s1_reg <= 1'b0;
            gd_s2_reg <= 1'b0;
        end else begin
            sc_s1_reg <= i_short_raw; // R25
            sc_s2_reg <= sc_s1_reg;
            gd_s1_reg <= i_good_raw; // R25
            gd_s2_reg <= gd_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state selection for the enable and soft-start sequence.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            sdc_pkg::SDC_OFF: begin
                if (en && (!flag_reg || local_up)) begin
                    state_next = sdc_pkg::SDC_DELAY; // R10
                end
            end
            sdc_pkg::SDC_DELAY: begin
                if (dly_done) begin
                    state_next = sdc_pkg::SDC_RAMP; // R17
                end
            end
            sdc_pkg::SDC_RAMP: begin
                if (ref_reg == i_code) begin
                    state_next = sdc_pkg::SDC_RUN; // R24
                end
            end
            sdc_pkg::SDC_RUN: begin
                state_next = sdc_pkg::SDC_RUN;
            end
            sdc_pkg::SDC_FAULT: begin
                if (!i_local_en) begin
                    state_next = sdc_pkg::SDC_OFF; // R20
                end
            end
            default: begin
                state_next = sdc_pkg::SDC_OFF;
            end
        endcase
        if (active && !en) begin
            state_next = sdc_pkg::SDC_OFF; // R15
        end
        if (short_hit) begin
            state_next = sdc_pkg::SDC_FAULT; // R19
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State, delay counter, reference and fault latch.
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg      <= sdc_pkg::SDC_OFF; // R11
            dly_reg        <= 11'h000;
            ref_reg        <= 7'h00;
            local_prev_reg <= 1'b0;
            flag_reg       <= 1'b0;
        end else begin
            state_reg      <= state_next;
            local_prev_reg <= i_local_en;
            if (state_reg == sdc_pkg::SDC_DELAY) begin
                dly_reg <= dly_reg + 11'h001;
            end else begin
                dly_reg <= 11'h000;
            end
            if (state_next == sdc_pkg::SDC_OFF || state_next == sdc_pkg::SDC_FAULT
                || state_next == sdc_pkg::SDC_DELAY) begin
                ref_reg <= 7'h00;
            end else if (state_reg == sdc_pkg::SDC_RUN) begin
                ref_reg <= i_code; // R14
            end else if (i_step_tick && ref_reg != i_code) begin
                ref_reg <= ref_reg + 7'h01; // R24
            end
            if (short_hit) begin
                flag_reg <= 1'b1; // R19
            end else if (local_up) begin
                flag_reg <= 1'b0; // R20
            end
        end
    end

    assign o_on         = active;
    assign o_ref_code   = ref_reg;
    assign o_ramping    = (state_reg == sdc_pkg::SDC_DELAY) || (state_reg == sdc_pkg::SDC_RAMP);
    assign o_short_flag = flag_reg;
    assign o_good       = gd_s2_reg; // R8
endmodule

// ---- hdl/sdc_top.sv ----
`timescale 1ns/1ps
`include "sdc_params.svh"

// What this block does
// R1: three channels, registers at 0x80 to 0x85.
// R2: code times 25 mV plus 0.75 V.
// R3: software keeps codes at or below 1110110.
// R4: voltage bit 7 is local enable, reset zero.
// R5: control bit 0 picks pulse-frequency mode.
// R6: control bit 1 picks 2 MHz, reset one.
// R7: control bits 3:2 set current limit, reset 11.
// R8: control bit 5 reads regulation good status.
// R9: control bit 7 unlocks top three code bits.
// R10: channel on needs master and local enable.
// R11: reset loads defaults; disabling keeps register contents.
// R12: defaults 3.3 V, 1.8 V, 1.2 V.
// R13: software writes code with enable bit.
// R14: new codes accepted while channel runs.
// R15: clearing either enable turns channel off.
// R16: software uses master enable for shutdown only.
// R17: 50 us delay, then ramp 80 us per volt.
// R18: code writes ignored during soft start.
// R19: short latches channel off and sets flag.
// R20: local enable low then high clears latch.
// R21: current limit holds, recovery needs no software.
// R22: master enable bits 0 to 2 per channel.
// R23: software programs settings before enabling.
// R24: reference steps one code every 2 us.
// R25: analog status inputs synchronised before use.
module sdc_top (
    input  wire logic        i_clk_sys,
    input  wire logic        i_arst_n,
    input  wire logic        i_wr_en,
    input  wire logic        i_rd_en,
    input  wire logic [7:0]  i_addr,
    input  wire logic [7:0]  i_wr_data,
    input  wire logic [2:0]  i_short_raw,
    input  wire logic [2:0]  i_good_raw,
    output logic      [7:0]  o_rd_data,
    output logic      [2:0]  o_ch_on,
    output logic      [20:0] o_ref_codes,
    output logic      [2:0]  o_pfm_mode,
    output logic      [2:0]  o_rate_2mhz,
    output logic      [5:0]  o_peak_limit
);
    ////////////////////////////////////////////////////////////////////////////////
    // Shared state.
    logic [2:0]  master_reg;
    logic [7:0]  rd_data_reg;
    logic [5:0]  step_cnt_reg;
    logic        step_tick_reg;
    logic [7:0]  rd_mux;

    logic [2:0]  ch_on_w;
    logic [2:0]  ramping_w;
    logic [2:0]  short_w;
    logic [2:0]  good_w;
    logic [20:0] ref_w;
    logic [23:0] volt_w;
    logic [23:0] ctrl_w;

    wire logic master_hit = (i_addr == `SDC_ADDR_MASTER_EN);

    ////////////////////////////////////////////////////////////////////////////////
    // Step divider: one-cycle enable pulse every 2 us.
    wire logic step_wrap = (step_cnt_reg == 6'(`SDC_STEP_CYC - 1));

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            step_cnt_reg  <= 6'h00;
            step_tick_reg <= 1'b0;
        end else begin
            step_cnt_reg  <= step_wrap ? 6'h00 : step_cnt_reg + 6'h01; // R24
            step_tick_reg <= step_wrap;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Master enable register.
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            master_reg <= `SDC_MASTER_RST;
        end else if (i_wr_en && master_hit) begin
            master_reg <= i_wr_data[2:0]; // R22
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-channel registers and soft-start sequencer.
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_ch
            logic [7:0] volt_reg;
            logic [7:0] ctrl_reg;
            logic [6:0] code_keep;
            logic [6:0] code_new;

            wire logic volt_hit = (i_addr == 8'(`SDC_ADDR_CH0_VOLT + 2 * g)); // R1
            wire logic ctrl_hit = (i_addr == 8'(`SDC_ADDR_CH0_CTRL + 2 * g)); // R1
            wire logic unlock   = ctrl_reg[`SDC_CTRL_UNLOCK_BIT];

            localparam logic [7:0] RST_VOLT = (g == 0) ? {1'b0, `SDC_CH0_CODE_RST} :
                                              (g == 1) ? {1'b0, `SDC_CH1_CODE_RST} :
                                                         {1'b0, `SDC_CH2_CODE_RST}; // R12
            assign code_new  = {unlock ? i_wr_data[6:4] : volt_reg[6:4], i_wr_data[3:0]}; // R9
            assign code_keep = ramping_w[g] ? volt_reg[6:0] : code_new; // R18

            always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    volt_reg <= RST_VOLT; // R4
                    ctrl_reg <= `SDC_CTRL_RST; // R5 R6 R7
                end else begin
                    if (i_wr_en && volt_hit) begin
                        volt_reg <= {i_wr_data[`SDC_VOLT_EN_BIT], code_keep}; // R14
                    end
                    if (i_wr_en && ctrl_hit) begin
                        ctrl_reg <= i_wr_data & `SDC_CTRL_RW_MASK;
                    end
                end
            end

            sdc_channel u_channel (
                .i_clk_sys    (i_clk_sys),
                .i_arst_n     (i_arst_n),
                .i_master_en  (master_reg[g]),
                .i_local_en   (volt_reg[`SDC_VOLT_EN_BIT]),
                .i_code       (volt_reg[6:0]),
                .i_step_tick  (step_tick_reg),
                .i_short_raw  (i_short_raw[g]),
                .i_good_raw   (i_good_raw[g]),
                .o_on         (ch_on_w[g]),
                .o_ref_code   (ref_w[7*g +: 7]),
                .o_ramping    (ramping_w[g]),
                .o_short_flag (short_w[g]),
                .o_good       (good_w[g])
            );

            assign volt_w[8*g +: 8] = volt_reg;
            assign ctrl_w[8*g +: 8] = {ctrl_reg[7:6], good_w[g], short_w[g], ctrl_reg[3:0]}; // R8 R19
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Read decode; unmapped addresses read zero.
    always_comb begin
        if (master_hit) begin
            rd_mux = {5'h00, master_reg};
        end else if (i_addr == `SDC_ADDR_CH0_VOLT) begin
            rd_mux = volt_w[7:0];
        end else if (i_addr == `SDC_ADDR_CH0_CTRL) begin
            rd_mux = ctrl_w[7:0];
        end else if (i_addr == `SDC_ADDR_CH1_VOLT) begin
            rd_mux = volt_w[15:8];
        end else if (i_addr == `SDC_ADDR_CH1_CTRL) begin
            rd_mux = ctrl_w[15:8];
        end else if (i_addr == `SDC_ADDR_CH2_VOLT) begin
            rd_mux = volt_w[23:16];
        end else if (i_addr == `SDC_ADDR_CH2_CTRL) begin
            rd_mux = ctrl_w[23:16];
        end else begin
            rd_mux = 8'h00;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rd_data_reg <= 8'h00;
        end else if (i_rd_en) begin
            rd_data_reg <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops except o_ch_on, a decode of channel state.
    assign o_rd_data    = rd_data_reg;
    assign o_ch_on      = ch_on_w; // R10
    assign o_ref_codes  = ref_w; // R2
    assign o_pfm_mode   = {ctrl_w[16], ctrl_w[8], ctrl_w[0]};
    assign o_rate_2mhz  = {ctrl_w[17], ctrl_w[9], ctrl_w[1]};
    assign o_peak_limit = {ctrl_w[19:18], ctrl_w[11:10], ctrl_w[3:2]}; // R21
endmodule

// ---- bench/sdc_top_assertions.sv ----
`timescale 1ns/1ps

module sdc_top_checker (
    input wire logic        i_clk_sys,
    input wire logic        i_arst_n,
    input wire logic        i_wr_en,
    input wire logic        i_rd_en,
    input wire logic [7:0]  i_addr,
    input wire logic [7:0]  i_wr_data,
    input wire logic [2:0]  i_short_raw,
    input wire logic [2:0]  i_good_raw,
    input wire logic [7:0]  o_rd_data,
    input wire logic [2:0]  o_ch_on,
    input wire logic [20:0] o_ref_codes,
    input wire logic [2:0]  o_pfm_mode,
    input wire logic [2:0]  o_rate_2mhz,
    input wire logic [5:0]  o_peak_limit
);
    logic [10:0] cnt_reg;
    logic [10:0] cnt_next;
    logic        mapped;

    // Cycles spent on by channel 0 since it last turned on.
    assign mapped = (i_addr == 8'h05) || (i_addr[7:3] == 5'h10 && i_addr[2:0] <= 3'h5);
    assign cnt_next = !o_ch_on[0] ? 11'h000 : (cnt_reg == 11'h7FF) ? cnt_reg : cnt_reg + 11'h001;
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) cnt_reg <= 11'h000;
        else cnt_reg <= cnt_next;
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking dc @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    sequence ctrl_wr_s; i_wr_en && i_addr == 8'h81; endsequence
    sequence ctrl_alone_s; ctrl_wr_s ##1 !(i_wr_en && i_addr == 8'h81); endsequence
    sequence good_held_s; i_good_raw[0] [*4]; endsequence

    unmapped_read_a: assert property (i_rd_en && !mapped |=> o_rd_data == 8'h00)
        else $error("unmapped read not zero");
    read_hold_a: assert property (!i_rd_en |=> $stable(o_rd_data)) else $error("read data moved");
    master_off_a: assert property (i_wr_en && i_addr == 8'h05 && !i_wr_data[0] |-> ##2 !o_ch_on[0])
        else $error("master clear left channel on");
    local_off_a: assert property (i_wr_en && i_addr == 8'h80 && !i_wr_data[7] |-> ##2 !o_ch_on[0])
        else $error("local clear left channel on");
    short_off_a: assert property (i_short_raw[0] [*5] |-> !o_ch_on[0])
        else $error("short did not turn channel off");
    delay_zero_a: assert property (o_ch_on[0] && cnt_reg < 11'h3E8 |-> o_ref_codes[6:0] == 7'h00)
        else $error("reference moved during start delay");
    ramp_start_a: assert property (o_ch_on[0] && cnt_reg == 11'h424 |-> o_ref_codes[6:0] != 7'h00)
        else $error("ramp did not start");
    ctrl_out_a: assert property (ctrl_alone_s |-> ##1 (o_pfm_mode[0] == $past(i_wr_data[0], 2)
        && o_rate_2mhz[0] == $past(i_wr_data[1], 2) && o_peak_limit[1:0] == $past(i_wr_data[3:2], 2)))
        else $error("control outputs differ from write");
    good_read_a: assert property (good_held_s ##0 (i_rd_en && i_addr == 8'h81) |=> o_rd_data[5])
        else $error("regulation status not read back");
endmodule

bind sdc_top sdc_top_checker i_chk (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_short_raw(i_short_raw),
    .i_good_raw(i_good_raw), .o_rd_data(o_rd_data), .o_ch_on(o_ch_on), .o_ref_codes(o_ref_codes),
    .o_pfm_mode(o_pfm_mode), .o_rate_2mhz(o_rate_2mhz), .o_peak_limit(o_peak_limit));

// ---- bench/step_down_converter_control_tb_top.sv ----
`timescale 1ns/1ps

module step_down_converter_control_tb_top;
    logic        clk_sys = 1'b0;
    logic        arst_n = 1'b0;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wr_data = 8'h00;
    logic [2:0]  short_raw = 3'h0;
    logic [2:0]  good_raw = 3'h0;
    logic [7:0]  rd_data;
    logic [2:0]  ch_on;
    logic [20:0] ref_codes;
    logic [2:0]  pfm;
    logic [2:0]  rate;
    logic [5:0]  plim;
    int          n_mismatch = 0;
    int          tests_run = 0;
    logic [7:0]  ra [9] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h05, 8'h86, 8'h04};
    logic [7:0]  rv [9] = '{8'h66, 8'hCE, 8'h2A, 8'hCE, 8'h12, 8'hCE, 8'h00, 8'h00, 8'h00};

    always #25 clk_sys = ~clk_sys;

    sdc_top i_dut (.i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_wr_en(wr_en), .i_rd_en(rd_en),
        .i_addr(addr), .i_wr_data(wr_data), .i_short_raw(short_raw), .i_good_raw(good_raw),
        .o_rd_data(rd_data), .o_ch_on(ch_on), .o_ref_codes(ref_codes), .o_pfm_mode(pfm),
        .o_rate_2mhz(rate), .o_peak_limit(plim));

    ////////////////////////////////////////////////////////////////////////////////
    task end_sim;
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task check(input logic [20:0] got, input logic [20:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #5;
        wr_en = 1'b1;
        addr = a;
        wr_data = d;
        @(posedge clk_sys);
        #5;
        wr_en = 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        #5;
        rd_en = 1'b1;
        addr = a;
        @(posedge clk_sys);
        #5;
        rd_en = 1'b0;
        check(rd_data, e);
    endtask

    task wait_on(input logic e);
        int n;
        n = 0;
        while (ch_on[0] !== e && n < 20) begin
            @(posedge clk_sys);
            #5;
            n++;
        end
        check(ch_on[0], e);
        if (ch_on[0] !== e) end_sim();
    endtask

    task wait_ref(input logic [6:0] e);
        int n;
        n = 0;
        while (ref_codes[6:0] !== e && n < 2000) begin
            @(posedge clk_sys);
            #5;
            n++;
        end
        check(ref_codes[6:0], e);
        if (ref_codes[6:0] !== e) end_sim();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #2000000;
        n_mismatch++;
        end_sim();
    end

    initial begin
        repeat (20) @(posedge clk_sys);
        #5;
        arst_n = 1'b1;
        for (int i = 0; i < 9; i++) rd(ra[i], rv[i]);
        check({pfm, rate, plim}, {3'h0, 3'h7, 6'h3F});
        $display("test 1 done");
        for (int k = 0; k < 4; k++) begin
            wr(8'h81, {4'hF, k[1:0], 2'b01});
            rd(8'h81, {4'hC, k[1:0], 2'b01});
            check({pfm[0], rate[0], plim[1:0]}, {2'b10, k[1:0]});
        end
        wr(8'h81, 8'hCE);
        $display("test 2 done");
        wr(8'h83, 8'h4E);
        wr(8'h82, 8'h76);
        rd(8'h82, 8'h26);
        wr(8'h83, 8'hCE);
        wr(8'h82, 8'h76);
        rd(8'h82, 8'h76);
        $display("test 3 done");
        wr(8'h05, 8'h01);
        repeat (3) @(posedge clk_sys);
        #5;
        check(ch_on[0], 1'b0);
        wr(8'h80, 8'h84);
        wait_on(1'b1);
        wr(8'h80, 8'h90);
        rd(8'h80, 8'h84);
        check(ref_codes[6:0], 7'h00);
        wait_ref(7'h04);
        wr(8'h80, 8'h86);
        wait_ref(7'h06);
        $display("test 4 done");
        wr(8'h80, 8'h06);
        wait_on(1'b0);
        rd(8'h80, 8'h06);
        wr(8'h80, 8'h86);
        wait_on(1'b1);
        wr(8'h05, 8'h00);
        wait_on(1'b0);
        rd(8'h80, 8'h86);
        $display("test 5 done");
        wr(8'h80, 8'h06);
        wr(8'h05, 8'h01);
        wr(8'h80, 8'h86);
        wait_on(1'b1);
        short_raw = 3'h1;
        wait_on(1'b0);
        rd(8'h81, 8'hDE);
        short_raw = 3'h0;
        wr(8'h80, 8'h86);
        repeat (3) @(posedge clk_sys);
        #5;
        check(ch_on[0], 1'b0);
        rd(8'h81, 8'hDE);
        wr(8'h80, 8'h06);
        wr(8'h80, 8'h86);
        wait_on(1'b1);
        rd(8'h81, 8'hCE);
        $display("test 6 done");
        good_raw = 3'h7;
        repeat (4) @(posedge clk_sys);
        rd(8'h81, 8'hEE);
        rd(8'h85, 8'hEE);
        good_raw = 3'h0;
        repeat (2) @(posedge clk_sys);
        #5;
        rd(8'h81, 8'hCE);
        check(ch_on[0], 1'b1);
        $display("test 7 done");
        arst_n = 1'b0;
        repeat (2) @(posedge clk_sys);
        #5;
        arst_n = 1'b1;
        check(ch_on, 3'h0);
        rd(8'h80, 8'h66);
        rd(8'h05, 8'h00);
        $display("test 8 done");
        end_sim();
    end
endmodule
